// file: design/ppm_params.svh
// Purpose: Constants for the power-state and data reporting register block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Offsets of the control/status, bridge and data words are local choices
//
// How it works
// (RULE1) Two-bit power state: 00 D0, 01 D1, 10 D2, 11 D3hot; reads current.
// (RULE2) Writing a supported value into bits 1..0 moves the function there.
// (RULE3) Unsupported state written: bus completes okay, data dropped, state kept.
// (RULE4) Software writes reserved control/status bits with their reset value.
// (RULE5) Bridge bit 7 reads 1 when secondary power/clock control is enabled.
// (RULE6) With control disabled, state writes never touch secondary power or clock.
// (RULE7) Bridge bit 6: 1 means D3hot stops clock (B2), 0 removes power (B3).
// (RULE8) The D3hot select bit only matters while the enable bit is 1.
// (RULE9) D0 and D1 take no bus action; D2 stops the secondary clock.
// (RULE10) D3hot stops clock and, for B3, removes power; D3cold adds nothing.
// (RULE11) Eight-bit read-only data register resets to 00 and follows data select.
// (RULE12) Data value is interpreted with the scale field of control/status.
// (RULE13) Data register reports state-dependent figures such as power or heat.
// (RULE14) Four-bit data select at bits 12..9 chooses the reported figure.
// (RULE15) Without a data register, the scale field reads 00.
// (RULE16) Bridge register ignores writes; reserved bits 5..0 read zero.
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ==========================================
// Register byte addresses
`define PPM_ADDR_CTRL_STATUS  8'h00
`define PPM_ADDR_BRIDGE_EXT   8'h04
`define PPM_ADDR_DATA_REPORT  8'h08
`define PPM_ADDR_W            8

// ==========================================
// Field positions
`define PPM_PS_LSB            0
`define PPM_PS_MSB            1
`define PPM_SEL_LSB           9
`define PPM_SEL_MSB           12
`define PPM_SCALE_LSB         13
`define PPM_SCALE_MSB         14
`define PPM_BSE_EN_BIT        7
`define PPM_BSE_SEL_BIT       6

// ==========================================
// Reset values
`define PPM_PS_RESET          2'h0
`define PPM_SEL_RESET         4'h0
`define PPM_DATA_RESET        8'h00
`define PPM_SUPPORT_ALL       4'hF

// ==========================================
// Bus responses
`define PPM_RESP_OKAY         2'h0
`define PPM_RESP_SLVERR       2'h2

`endif

// file: design/ppm_pkg.sv
// Purpose: Types for the power-state and data reporting block
// Assumes: Used with ppm_params.svh
// Notes:   No constants here, only types
package ppm_pkg;

    typedef enum logic [1:0] {
        PPM_D0    = 2'h0,
        PPM_D1    = 2'h1,
        PPM_D2    = 2'h2,
        PPM_D3HOT = 2'h3
    } ppm_pstate_t;

    typedef enum logic [1:0] {
        PPM_BS_IDLE = 2'h0,
        PPM_BS_RESP = 2'h1
    } ppm_bstate_t;

endpackage : ppm_pkg

// file: design/ppm_bus_ctl.sv
// Purpose: Maps the function power state onto secondary bus clock and power
// Assumes: Same clock as the register block
// Notes:   Outputs registered; D3cold is the loss of power itself, no logic here
`timescale 1ns/100ps
`include "ppm_params.svh"

module ppm_bus_ctl (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Control
    input  wire ppm_pkg::ppm_pstate_t pstate,
    input  wire logic               ctl_enable,
    input  wire logic               d3_clk_stop_sel,
    // Secondary bus
    output logic                    clk_stop,
    output logic                    pwr_off
);

    typedef struct packed {
        logic clk_stop;
        logic pwr_off;
    } ppm_bc_state_t;

    ppm_bc_state_t st_r;
    ppm_bc_state_t st_nxt;

    always_comb begin
        st_nxt = '{clk_stop: 1'b0, pwr_off: 1'b0};
        if (ctl_enable) begin // RULE6
            unique case (pstate)
                ppm_pkg::PPM_D0,
                ppm_pkg::PPM_D1: begin
                    st_nxt = '{clk_stop: 1'b0, pwr_off: 1'b0}; // RULE9
                end
                ppm_pkg::PPM_D2: begin
                    st_nxt = '{clk_stop: 1'b1, pwr_off: 1'b0}; // RULE9
                end
                ppm_pkg::PPM_D3HOT: begin
                    st_nxt.clk_stop = 1'b1; // RULE10
                    st_nxt.pwr_off  = ~d3_clk_stop_sel; // RULE7 RULE8 RULE10
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '{clk_stop: 1'b0, pwr_off: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_stop = st_r.clk_stop;
    assign pwr_off  = st_r.pwr_off;

endmodule : ppm_bus_ctl

// file: design/ppm_regs.sv
// Purpose: Power-state, bridge extension and data report registers on AXI4-Lite
// Assumes: 25 MHz CLK, synchronous active-high SYS_RST; bus master holds one
//          write and one read at most
// Notes:   Figures for the data register come in on DATA_TABLE, one byte per
//          select code; scale on SCALE_TABLE, two bits per select code
`timescale 1ns/100ps
`include "ppm_params.svh"

module ppm_regs #(
    parameter bit       DATA_PRESENT   = 1'b1,
    parameter bit       BRIDGE_CTL_EN  = 1'b0,
    parameter bit       D3_CLK_STOP    = 1'b0,
    parameter bit [3:0] STATE_SUPPORT  = `PPM_SUPPORT_ALL,
    parameter int       SEL_COUNT      = 16
) (
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          SYS_RST,
    // AXI4-Lite write address
    input  wire logic [7:0]    S_AXI_AWADDR,
    input  wire logic [2:0]    S_AXI_AWPROT,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]         S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]    S_AXI_ARADDR,
    input  wire logic [2:0]    S_AXI_ARPROT,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]        S_AXI_RDATA,
    output logic [1:0]         S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY,
    // Figure tables, same clock domain
    input  wire logic [127:0]  DATA_TABLE,
    input  wire logic [31:0]   SCALE_TABLE,
    // Function and secondary bus
    output logic [1:0]         POWER_STATE,
    output logic               SEC_CLK_STOP,
    output logic               SEC_PWR_OFF
);

    // Reset lands in D0, so D0 must always be supported
    if (SEL_COUNT != 16 || !STATE_SUPPORT[0]) begin : g_bad_params
        $error("SEL_COUNT must be 16 and D0 must be supported");
    end

    // ==========================================
    // State
    typedef struct packed {
        ppm_pkg::ppm_bstate_t  wst;
        logic                  aw_got;
        logic                  w_got;
        logic [7:0]            awaddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        ppm_pkg::ppm_pstate_t  pstate;
        logic [3:0]            data_sel;
        logic [7:0]            data_val;
        logic [1:0]            data_scale;
    } ppm_regs_state_t;

    ppm_regs_state_t st_r;
    ppm_regs_state_t st_nxt;

    // ==========================================
    // Helpers
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `PPM_ADDR_CTRL_STATUS) || (a == `PPM_ADDR_BRIDGE_EXT)
                  || (a == `PPM_ADDR_DATA_REPORT);
    endfunction : addr_known

    function automatic logic [7:0] pick_data(input logic [3:0] sel,
                                             input logic [127:0] tbl);
        pick_data = tbl[{sel, 3'h0} +: 8];
    endfunction : pick_data

    function automatic logic [1:0] pick_scale(input logic [3:0] sel,
                                              input logic [31:0] tbl);
        pick_scale = tbl[{sel, 1'h0} +: 2];
    endfunction : pick_scale

    logic [7:0] bridge_ext;
    logic [31:0] ctrl_word;

    always_comb begin
        // Read-only constant; writes never reach it
        bridge_ext = 8'h00; // RULE16
        bridge_ext[`PPM_BSE_EN_BIT]  = BRIDGE_CTL_EN; // RULE5
        bridge_ext[`PPM_BSE_SEL_BIT] = D3_CLK_STOP; // RULE7
        ctrl_word = 32'h0000_0000;
        ctrl_word[`PPM_PS_MSB:`PPM_PS_LSB] = st_r.pstate; // RULE1
        if (DATA_PRESENT) begin
            ctrl_word[`PPM_SEL_MSB:`PPM_SEL_LSB]     = st_r.data_sel; // RULE14
            ctrl_word[`PPM_SCALE_MSB:`PPM_SCALE_LSB] = st_r.data_scale; // RULE12
        end
        // Scale field stays zero without a data register
    end

    // ==========================================
    // Next state
    always_comb begin
        logic [1:0] new_ps;
        logic       do_write;
        new_ps   = 2'h0;
        do_write = 1'b0;
        st_nxt = st_r;
        st_nxt.awready = 1'b0;
        st_nxt.wready  = 1'b0;
        st_nxt.arready = 1'b0;

        // Figures follow the current select every cycle
        if (DATA_PRESENT) begin
            st_nxt.data_val   = pick_data(st_r.data_sel, DATA_TABLE); // RULE11 RULE13
            st_nxt.data_scale = pick_scale(st_r.data_sel, SCALE_TABLE); // RULE12
        end else begin
            st_nxt.data_val   = `PPM_DATA_RESET;
            st_nxt.data_scale = 2'h0; // RULE15
        end

        unique case (st_r.wst)
            ppm_pkg::PPM_BS_IDLE: begin
                // Address and data may arrive in either order
                if (S_AXI_AWVALID && st_r.awready) begin
                    st_nxt.aw_got = 1'b1;
                    st_nxt.awaddr = S_AXI_AWADDR;
                end else if (!st_r.aw_got && !st_r.awready) begin
                    st_nxt.awready = 1'b1;
                end
                if (S_AXI_WVALID && st_r.wready) begin
                    st_nxt.w_got = 1'b1;
                    st_nxt.wdata = S_AXI_WDATA;
                    st_nxt.wstrb = S_AXI_WSTRB;
                end else if (!st_r.w_got && !st_r.wready) begin
                    st_nxt.wready = 1'b1;
                end
                if (st_r.aw_got && st_r.w_got) begin
                    do_write = 1'b1;
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got  = 1'b0;
                    st_nxt.bvalid = 1'b1;
                    // Unsupported state still answers OKAY
                    st_nxt.bresp  = addr_known(st_r.awaddr) ? `PPM_RESP_OKAY
                                                            : `PPM_RESP_SLVERR; // RULE3
                    st_nxt.wst    = ppm_pkg::PPM_BS_RESP;
                end
            end
            ppm_pkg::PPM_BS_RESP: begin
                if (S_AXI_BREADY) begin
                    st_nxt.bvalid = 1'b0;
                    st_nxt.wst    = ppm_pkg::PPM_BS_IDLE;
                end
            end
            default: begin
                st_nxt.wst = ppm_pkg::PPM_BS_IDLE;
            end
        endcase

        // Only the control/status word is writable; reserved bits are dropped
        if (do_write && st_r.awaddr == `PPM_ADDR_CTRL_STATUS) begin // RULE4
            if (st_r.wstrb[0]) begin
                new_ps = st_r.wdata[`PPM_PS_MSB:`PPM_PS_LSB];
                if (STATE_SUPPORT[new_ps]) begin // RULE3
                    st_nxt.pstate = ppm_pkg::ppm_pstate_t'(new_ps); // RULE2
                end
            end
            // Select bits 12..9 all sit in byte lane 1
            if (DATA_PRESENT && st_r.wstrb[1]) begin
                st_nxt.data_sel = st_r.wdata[`PPM_SEL_MSB:`PPM_SEL_LSB]; // RULE14
            end
        end

        // Read channel
        if (st_r.rvalid) begin
            if (S_AXI_RREADY) begin
                st_nxt.rvalid = 1'b0;
            end
        end else if (S_AXI_ARVALID && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = `PPM_RESP_OKAY;
            if (S_AXI_ARADDR == `PPM_ADDR_CTRL_STATUS) begin
                st_nxt.rdata = ctrl_word; // RULE1
            end else if (S_AXI_ARADDR == `PPM_ADDR_BRIDGE_EXT) begin
                st_nxt.rdata = {24'h000000, bridge_ext}; // RULE16
            end else if (S_AXI_ARADDR == `PPM_ADDR_DATA_REPORT) begin
                st_nxt.rdata = {24'h000000, st_r.data_val}; // RULE11
            end else begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rresp = `PPM_RESP_SLVERR;
            end
        end else if (!st_r.arready) begin
            st_nxt.arready = 1'b1;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_r <= '{wst: ppm_pkg::PPM_BS_IDLE, pstate: ppm_pkg::PPM_D0,
                      data_sel: `PPM_SEL_RESET, data_val: `PPM_DATA_RESET,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign S_AXI_AWREADY = st_r.awready;
    assign S_AXI_WREADY  = st_r.wready;
    assign S_AXI_BVALID  = st_r.bvalid;
    assign S_AXI_BRESP   = st_r.bresp;
    assign S_AXI_ARREADY = st_r.arready;
    assign S_AXI_RVALID  = st_r.rvalid;
    assign S_AXI_RDATA   = st_r.rdata;
    assign S_AXI_RRESP   = st_r.rresp;
    assign POWER_STATE   = st_r.pstate;

    // ==========================================
    // Secondary bus control
    ppm_bus_ctl u_bus_ctl (
        .clk             (CLK),
        .rst             (SYS_RST),
        .pstate          (st_r.pstate),
        .ctl_enable      (BRIDGE_CTL_EN), // RULE6 RULE8
        .d3_clk_stop_sel (D3_CLK_STOP),
        .clk_stop        (SEC_CLK_STOP),
        .pwr_off         (SEC_PWR_OFF)
    );

endmodule : ppm_regs

// file: test/ppm_regs_properties.sv
// Purpose: Port-level checks on the power-state register block
// Assumes: Bound to ppm_regs; one clock, synchronous active-high reset
// Notes:   Secondary bus outputs lag the power state by one edge
`timescale 1ns/100ps

module ppm_regs_chk #(
    parameter bit BRIDGE_CTL_EN = 1'b0,
    parameter bit D3_CLK_STOP   = 1'b0
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        SYS_RST,
    // Bus
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // Function and secondary bus
    input wire logic [1:0]  POWER_STATE,
    input wire logic        SEC_CLK_STOP,
    input wire logic        SEC_PWR_OFF
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ==========================================
    // Secondary bus; guard skips the edge right after reset
    clk_stop_map_a: assert property (
        !$past(SYS_RST) |->
        SEC_CLK_STOP == (BRIDGE_CTL_EN && $past(POWER_STATE) >= 2'h2))
        else $error("clock stop does not follow state");
    pwr_off_map_a: assert property (
        !$past(SYS_RST) |->
        SEC_PWR_OFF == (BRIDGE_CTL_EN && !D3_CLK_STOP && $past(POWER_STATE) == 2'h3))
        else $error("power removal does not follow state");
    state_change_a: assert property (
        !$past(SYS_RST) && $changed(POWER_STATE) |-> $rose(S_AXI_BVALID))
        else $error("state moved without a write response");

    // ==========================================
    // Register bus
    bridge_read_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h04 |=>
        S_AXI_RDATA == {24'h0, BRIDGE_CTL_EN, D3_CLK_STOP, 6'h0} && S_AXI_RRESP == 2'h0)
        else $error("bridge word wrong");
    unmapped_read_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && !(S_AXI_ARADDR inside {8'h00, 8'h04, 8'h08})
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    read_answer_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    write_answer_a: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##2 S_AXI_BVALID)
        else $error("write answer late");
    resp_hold_a: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    data_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    ready_pulse_a: assert property (
        S_AXI_ARREADY |=> !S_AXI_ARREADY)
        else $error("read ready not a pulse");
endmodule : ppm_regs_chk

bind ppm_regs ppm_regs_chk #(
    .BRIDGE_CTL_EN (BRIDGE_CTL_EN),
    .D3_CLK_STOP   (D3_CLK_STOP)
) ppm_regs_chk_i (
    .CLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .POWER_STATE, .SEC_CLK_STOP, .SEC_PWR_OFF
);

// file: test/ppm_regs_tb.sv
// Purpose: Self-checking bench for the power-state register block
// Assumes: Bridge control on, D3hot removes power, D1 unsupported
// Notes:   Tables re-drawn each pass so data and scale track the select;
//          side copies cover control off and the D3hot clock-stop choice
`timescale 1ns/100ps
`include "ppm_params.svh"

module ppm_regs_tb;
    localparam bit [3:0] SUPPORT = 4'hD;

    logic         clk, rst, aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic [7:0]   aw_addr, ar_addr;
    logic [31:0]  w_data, scale_tbl, rd;
    logic [3:0]   w_strb, sel, st, sel_m;
    logic [127:0] data_tbl;
    logic [1:0]   s, rs, ps_m;
    logic [7:0]   corner = 8'h63;
    wire logic    aw_ready, w_ready, b_valid, ar_ready, r_valid, clk_stop, pwr_off;
    wire logic [1:0]  alt_stop, alt_off;
    wire logic [1:0]  b_resp, r_resp, pstate;
    wire logic [31:0] r_data;
    integer       seed = 32'hEB04422A;
    int           err_total = 0;
    int           cmp_count = 0;

    ppm_regs #(.BRIDGE_CTL_EN(1'b1), .D3_CLK_STOP(1'b0), .STATE_SUPPORT(SUPPORT)) ppm_regs_i (
        .CLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
        .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .DATA_TABLE(data_tbl), .SCALE_TABLE(scale_tbl),
        .POWER_STATE(pstate), .SEC_CLK_STOP(clk_stop), .SEC_PWR_OFF(pwr_off)
    );

    // Side copies on the same bus: index 0 control off, index 1 D3hot stops clock
    for (genvar g = 0; g < 2; g++) begin : g_alt
        ppm_regs #(
            .BRIDGE_CTL_EN (g == 1),
            .D3_CLK_STOP   (1'b1),
            .STATE_SUPPORT (SUPPORT)
        ) ppm_regs_i (
            .CLK(clk), .SYS_RST(rst),
            .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(aw_valid),
            .S_AXI_AWREADY(), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
            .S_AXI_WVALID(w_valid), .S_AXI_WREADY(), .S_AXI_BRESP(),
            .S_AXI_BVALID(), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
            .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(),
            .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(),
            .S_AXI_RREADY(r_ready), .DATA_TABLE(data_tbl), .SCALE_TABLE(scale_tbl),
            .POWER_STATE(), .SEC_CLK_STOP(alt_stop[g]), .SEC_PWR_OFF(alt_off[g])
        );
    end

    // ==========================================
    // Bus tasks; ready raised late on purpose so the slave must hold its answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
                          output logic [1:0] r);
        @(posedge clk);
        aw_addr  <= a;
        w_data   <= d;
        w_strb   <= m;
        aw_valid <= 1'b1;
        w_valid  <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
        end while (!b_valid);
        b_ready <= 1'b1;
        @(posedge clk);
        r = b_resp;
        b_ready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ar_addr  <= a;
        ar_valid <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_ready) ar_valid <= 1'b0;
        end while (!r_valid);
        r_ready <= 1'b1;
        @(posedge clk);
        d = r_data;
        r = r_resp;
        r_ready <= 1'b0;
    endtask : axi_rd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] ctrl_exp(input logic [1:0] p, input logic [3:0] c);
        ctrl_exp = {17'h0, scale_tbl[2*c +: 2], c, 7'h0, p};
    endfunction : ctrl_exp

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ==========================================
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial begin
        {rst, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 6'h20;
        {aw_addr, ar_addr, w_data, w_strb, data_tbl, scale_tbl} = '0;
        ps_m = 2'h0;
        sel_m = 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_rd(`PPM_ADDR_DATA_REPORT, rd, rs);
        check(rd, 32'h0);
        axi_rd(`PPM_ADDR_CTRL_STATUS, rd, rs);
        check(rd, ctrl_exp(2'h0, 4'h0));
        axi_wr(`PPM_ADDR_BRIDGE_EXT, 32'hFF, 4'hF, rs);
        check(rs, `PPM_RESP_OKAY);
        axi_rd(`PPM_ADDR_BRIDGE_EXT, rd, rs);
        check(rd, 32'h80);
        axi_wr(`PPM_ADDR_DATA_REPORT, 32'hFF, 4'hF, rs);
        check(rs, `PPM_RESP_OKAY);
        axi_wr(8'h0C, 32'h3, 4'hF, rs);
        check(rs, `PPM_RESP_SLVERR);
        axi_rd(8'h0C, rd, rs);
        check(rd, 32'h0);
        check(rs, `PPM_RESP_SLVERR);
        check(pstate, 2'h0);
        // Corner order first: D3hot, D0, D2, then unsupported D1 while in D2
        for (int i = 0; i < 28; i++) begin
            s = (i < 4) ? corner[2*i +: 2] : 2'($random(seed));
            sel = 4'($random(seed));
            st = (i < 4) ? 4'hF : 4'($random(seed));
            data_tbl <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            scale_tbl <= $random(seed);
            axi_wr(`PPM_ADDR_CTRL_STATUS, {19'h0, sel, 7'h0, s}, st, rs);
            if (st[0] && SUPPORT[s]) ps_m = s;
            if (st[1]) sel_m = sel;
            check(rs, `PPM_RESP_OKAY);
            axi_rd(`PPM_ADDR_CTRL_STATUS, rd, rs);
            check(rd, ctrl_exp(ps_m, sel_m));
            check(pstate, ps_m);
            check(clk_stop, ps_m >= 2'h2);
            check(pwr_off, ps_m == 2'h3);
            check(alt_stop[0], 1'b0);
            check(alt_off[0], 1'b0);
            check(alt_stop[1], ps_m >= 2'h2);
            check(alt_off[1], 1'b0);
            axi_rd(`PPM_ADDR_DATA_REPORT, rd, rs);
            check(rd, data_tbl[8*sel_m +: 8]);
        end
        summarize();
    end
endmodule : ppm_regs_tb
